// >>> cwd_config_decoder.sv
// configuration word one decoder: latches the word, drives static control outputs
// assumes cfgWord comes from a store outside this clock domain, stable when cfgLoad pulses
// assumes the register port master never raises both strobes in one cycle
//
// Operation
// [R1] debugger-disable bit 13 set frees serial programming pins; clear reserves them
// [R2] low-voltage programming off: pin is digital I/O, high-voltage entry only
// [R3] reset pin disabled: pin is digital input, internal reset held inactive high
// [R4] watchdog fuse clear: watchdog runs only when software enable set; else always
// [R5] data protection going enabled to disabled erases whole data EEPROM
// [R6] program protection going enabled to disabled erases whole program memory
// [R7] clock source field picks one of eight oscillator modes and pin roles
`timescale 1ns/1ps
`default_nettype none
module cwd_config_decoder
   import cwd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [13:0] cfgWord,
   input wire logic cfgLoad,
   input wire logic extResetPinIn,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [13:0] regRdata,
   output logic debuggerEnable,
   output logic serialPinsGpio,
   output logic lowVoltProgPinFunc,
   output logic highVoltEntryOnly,
   output logic resetPinGpio,
   output logic resetPinInternal,
   output logic watchdogRun,
   output logic dataEraseReq,
   output logic progEraseReq,
   output logic [2:0] oscMode,
   output logic oscPinsClock,
   output logic clkoutEnable,
   output logic failsafeClockMonitorEnable,
   output logic clockSwitchoverEnable,
   output logic [1:0] brownoutResetSelect,
   output logic powerUpDelayEnable
);
   logic [13:0] cfgSync1_r, cfgSync2_r, cfg_r;
   logic [2:0] loadSync_r;
   logic rstSync1_r, rstSync2_r;
   logic wdtSwEn_r;
   logic dataProt_r, progProt_r, loaded_r;
   cwd_state_type state_r;
   logic loadPulse;
   cwd_osc_type osc;

   // pin-side inputs: two flops each before any logic reads them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgSync1_r <= CFG_RESET;
         cfgSync2_r <= CFG_RESET;
         loadSync_r <= 3'h0;
         rstSync1_r <= 1'b1;
         rstSync2_r <= 1'b1;
      end else begin
         cfgSync1_r <= cfgWord;
         cfgSync2_r <= cfgSync1_r;
         loadSync_r <= {loadSync_r[1:0], cfgLoad};
         rstSync1_r <= extResetPinIn;
         rstSync2_r <= rstSync1_r;
      end
   end

   // rising edge of the synchronised load request
   assign loadPulse = loadSync_r[1] & ~loadSync_r[2];

   // two-step load lets the synchronised word settle one more cycle
   // a request seen while ST_LOAD is busy is dropped
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cfg_r <= CFG_RESET;
         loaded_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (loadPulse) begin
                  state_r <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               cfg_r <= cfgSync2_r;
               loaded_r <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // protection history for erase on turn-off
   // first load after reset has no history, so it never erases
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataProt_r <= 1'b0;
         progProt_r <= 1'b0;
         dataEraseReq <= 1'b0;
         progEraseReq <= 1'b0;
      end else begin
         dataEraseReq <= 1'b0;
         progEraseReq <= 1'b0;
         if (state_r == ST_LOAD) begin
            dataProt_r <= ~cfgSync2_r[POS_DATA_PROT_N];
            progProt_r <= ~cfgSync2_r[POS_PROG_PROT_N];
            dataEraseReq <= loaded_r & dataProt_r & cfgSync2_r[POS_DATA_PROT_N]; // [R5]
            progEraseReq <= loaded_r & progProt_r & cfgSync2_r[POS_PROG_PROT_N]; // [R6]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdtSwEn_r <= 1'b0;
      // software watchdog enable is the only writable bit
      end else if (regWrite && regAddr == ADDR_WDT_CTRL) begin
         wdtSwEn_r <= regWdata[POS_WDT_SW_EN];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 14'h0000;
      // read data stand only in the cycle after the read strobe
      end else if (regRead) begin
         case (regAddr)
            ADDR_CFG_WORD: regRdata <= cfg_r;
            ADDR_WDT_CTRL: regRdata <= {13'h0000, wdtSwEn_r};
            ADDR_STATUS: regRdata <= {11'h000, watchdogRun, dataProt_r, progProt_r};
            default: regRdata <= 14'h0000;
         endcase
      end else begin
         regRdata <= 14'h0000;
      end
   end

   // oscillator field as an enum for the mode decode
   assign osc = cwd_osc_type'(cfg_r[POS_CLK_HI:POS_CLK_LO]);

   // reset values equal the decode of the erased word, so outputs do not
   // step when reset lifts
   // debugger and programming pin ownership
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         debuggerEnable <= 1'b0;
         serialPinsGpio <= 1'b1;
         lowVoltProgPinFunc <= 1'b1;
         highVoltEntryOnly <= 1'b0;
      end else begin
         debuggerEnable <= ~cfg_r[POS_DEBUG_DIS]; // [R1]
         serialPinsGpio <= cfg_r[POS_DEBUG_DIS]; // [R1]
         lowVoltProgPinFunc <= cfg_r[POS_LVP_EN]; // [R2]
         highVoltEntryOnly <= ~cfg_r[POS_LVP_EN]; // [R2]
      end
   end

   // pin disabled: internal reset parked at its inactive level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         resetPinGpio <= 1'b0;
         resetPinInternal <= 1'b1;
      end else begin
         resetPinGpio <= ~cfg_r[POS_RESET_PIN_EN]; // [R3]
         resetPinInternal <= cfg_r[POS_RESET_PIN_EN] ? rstSync2_r : 1'b1; // [R3]
      end
   end

   // fuse forces the watchdog on; otherwise software decides
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdogRun <= 1'b1;
      end else begin
         watchdogRun <= cfg_r[POS_WDT_FUSE] | wdtSwEn_r; // [R4]
      end
   end

   // oscillator mode and the role of the two oscillator pins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscMode <= 3'h7;
         oscPinsClock <= 1'b0;
         clkoutEnable <= 1'b1;
      end else begin
         oscMode <= osc; // [R7]
         case (osc)
            OSC_LP, OSC_XT, OSC_HS: begin
               oscPinsClock <= 1'b1; // [R7]
               clkoutEnable <= 1'b0;
            end
            OSC_INT_CLKOUT, OSC_RC_CLKOUT: begin
               oscPinsClock <= 1'b0;
               clkoutEnable <= 1'b1; // [R7]
            end
            default: begin
               oscPinsClock <= 1'b0;
               clkoutEnable <= 1'b0;
            end
         endcase
      end
   end

   // fields passed through for blocks outside this decoder
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         failsafeClockMonitorEnable <= 1'b1;
         clockSwitchoverEnable <= 1'b1;
         brownoutResetSelect <= 2'h3;
         powerUpDelayEnable <= 1'b0;
      end else begin
         failsafeClockMonitorEnable <= cfg_r[POS_FCM_EN];
         clockSwitchoverEnable <= cfg_r[POS_SWITCHOVER_EN];
         brownoutResetSelect <= cfg_r[POS_BOR_HI:POS_BOR_LO];
         powerUpDelayEnable <= ~cfg_r[POS_PWRUP_DELAY_N];
      end
   end
endmodule
`default_nettype wire

// >>> cwd_pkg.sv
// package for the configuration word decoder: field positions, reset values, modes
// assumes a 14-bit configuration word presented by the non-volatile store
package cwd_pkg;
   localparam int CFG_WIDTH = 14;
   localparam int POS_DEBUG_DIS = 13;
   localparam int POS_LVP_EN = 12;
   localparam int POS_FCM_EN = 11;
   localparam int POS_SWITCHOVER_EN = 10;
   localparam int POS_BOR_HI = 9;
   localparam int POS_BOR_LO = 8;
   localparam int POS_DATA_PROT_N = 7;
   localparam int POS_PROG_PROT_N = 6;
   localparam int POS_RESET_PIN_EN = 5;
   localparam int POS_PWRUP_DELAY_N = 4;
   localparam int POS_WDT_FUSE = 3;
   localparam int POS_CLK_HI = 2;
   localparam int POS_CLK_LO = 0;
   // erased (unprogrammed) word reads all ones
   localparam logic [13:0] CFG_RESET = 14'h3fff;
   localparam logic [1:0] ADDR_CFG_WORD = 2'h0;
   localparam logic [1:0] ADDR_WDT_CTRL = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   localparam int POS_WDT_SW_EN = 0;
   typedef enum logic [2:0] {
      OSC_LP, OSC_XT, OSC_HS, OSC_EC, OSC_INT_IO, OSC_INT_CLKOUT, OSC_RC_IO, OSC_RC_CLKOUT
   } cwd_osc_type;
   typedef enum {ST_IDLE, ST_LOAD} cwd_state_type;
endpackage

// >>> cwd_config_decoder_assertions.sv
// checker: relations between the decoder's registered outputs
// assumes binding onto cwd_config_decoder, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cwd_chk
   import cwd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic debuggerEnable,
   input wire logic serialPinsGpio,
   input wire logic lowVoltProgPinFunc,
   input wire logic highVoltEntryOnly,
   input wire logic resetPinGpio,
   input wire logic resetPinInternal,
   input wire logic dataEraseReq,
   input wire logic progEraseReq,
   input wire logic [2:0] oscMode,
   input wire logic oscPinsClock,
   input wire logic clkoutEnable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_dbg; debuggerEnable != serialPinsGpio; endproperty
   a_dbg: assert property (p_dbg) else $error("debug pin owner wrong");
   property p_lvp; lowVoltProgPinFunc != highVoltEntryOnly; endproperty
   a_lvp: assert property (p_lvp) else $error("programming entry wrong");
   property p_rst; resetPinGpio |-> resetPinInternal; endproperty
   a_rst: assert property (p_rst) else $error("internal reset not inactive");
   property p_dat; dataEraseReq |=> !dataEraseReq; endproperty
   a_dat: assert property (p_dat) else $error("data erase not a pulse");
   property p_prg; progEraseReq |=> !progEraseReq; endproperty
   a_prg: assert property (p_prg) else $error("program erase not a pulse");
   property p_pin; oscPinsClock == (oscMode < 3'h3); endproperty
   a_pin: assert property (p_pin) else $error("oscillator pin role wrong");
   property p_clk; clkoutEnable == (oscMode == 3'h5 || oscMode == 3'h7); endproperty
   a_clk: assert property (p_clk) else $error("clock out wrong");
   property p_osc; $changed(oscMode) |=> $stable(oscMode); endproperty
   a_osc: assert property (p_osc) else $error("mode not held");
endmodule
bind cwd_config_decoder cwd_chk chk (.*);
`default_nettype wire

// >>> tb_config_word_decoder.sv
// testbench: loads words, compares decode with a model
// assumes cwd_pkg and cwd_config_decoder compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g)!==(e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_config_word_decoder
   import cwd_pkg::*;
;
   logic ref_clk, rst_n, cfgLoad, extResetPinIn, regWrite, regRead, sw;
   logic [13:0] cfgWord, regRdata, w, prev;
   logic [1:0] regAddr, brownoutResetSelect;
   logic [7:0] regWdata;
   logic [2:0] oscMode;
   logic debuggerEnable, serialPinsGpio, lowVoltProgPinFunc, highVoltEntryOnly;
   logic resetPinGpio, resetPinInternal, watchdogRun, dataEraseReq, progEraseReq;
   logic oscPinsClock, clkoutEnable, failsafeClockMonitorEnable, clockSwitchoverEnable;
   logic powerUpDelayEnable;
   int n_mismatch = 0, checked = 0, cyc = 0, nd = 0, np = 0, ed = 0, ep = 0;
   cwd_config_decoder uut (.*);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      nd += int'(dataEraseReq);
      np += int'(progEraseReq);
      if (cyc == 2000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task finish_test();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [1:0] a, input logic [13:0] e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(negedge ref_clk);
      `CHK("rdata", e, regRdata)
      @(posedge ref_clk);
   endtask
   task ld(input logic [13:0] v);
      cfgWord <= v;
      extResetPinIn <= 1'($urandom);
      repeat (4) @(posedge ref_clk);
      cfgLoad <= 1'b1;
      repeat (3) @(posedge ref_clk);
      cfgLoad <= 1'b0;
      repeat (8) @(posedge ref_clk);
      ed += int'(!prev[7] && v[7]);
      ep += int'(!prev[6] && v[6]);
      #1 `CHK("debug", ~v[13], debuggerEnable)
      `CHK("serialpins", v[13], serialPinsGpio)
      `CHK("lowvolt", v[12], lowVoltProgPinFunc)
      `CHK("hventry", ~v[12], highVoltEntryOnly)
      `CHK("rstgpio", ~v[5], resetPinGpio)
      `CHK("rstint", v[5] ? extResetPinIn : 1'b1, resetPinInternal)
      `CHK("wdt", v[3] | sw, watchdogRun)
      `CHK("dataerase", ed, nd)
      `CHK("progerase", ep, np)
      `CHK("osc", v[2:0], oscMode)
      `CHK("oscpins", v[2:0] < 3'h3, oscPinsClock)
      `CHK("clkout", v[2:0] == 3'h5 || v[2:0] == 3'h7, clkoutEnable)
      `CHK("failsafe", v[11], failsafeClockMonitorEnable)
      `CHK("switchover", v[10], clockSwitchoverEnable)
      `CHK("brownout", v[9:8], brownoutResetSelect)
      `CHK("pwrup", ~v[4], powerUpDelayEnable)
      @(posedge ref_clk);
      rd(ADDR_CFG_WORD, v);
      rd(ADDR_STATUS, {11'h000, v[3] | sw, ~v[7], ~v[6]});
      prev = v;
   endtask
   initial begin
      rst_n = 1'b0;
      {cfgLoad, extResetPinIn, regWrite, regRead, sw} = 5'h02;
      {cfgWord, prev, regAddr, regWdata} = {CFG_RESET, CFG_RESET, 10'h0};
      void'($urandom(2));
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1 `CHK("oscpins", 1'b0, oscPinsClock)
      @(posedge ref_clk);
      rd(2'h3, 14'h0);
      for (int i = 0; i < 16; i++) begin
         w = 14'($urandom);
         w[2:0] = 3'(i);
         w[7:6] = 2'(i);
         if (i == 4) wr(ADDR_CFG_WORD, 8'h00);
         if (i == 8) begin
            wr(ADDR_WDT_CTRL, 8'h01);
            sw = 1'b1;
            rd(ADDR_WDT_CTRL, 14'h1);
         end
         ld(w);
      end
      finish_test();
   end
endmodule
`default_nettype wire
